// File: hdl/kbc_params.svh
`ifndef KBC_PARAMS_SVH
`define KBC_PARAMS_SVH

// Register addresses on the host port
`define KBC_A_DATA      8'h60
`define KBC_A_CMD       8'h64
`define KBC_A_P92       8'h92
`define KBC_A_CTRL      8'hF0

// Command codes
`define KBC_C_KB_TEST   8'hAB
`define KBC_C_KB_DIS    8'hAD
`define KBC_C_KB_EN     8'hAE
`define KBC_C_RD_P1     8'hC0
`define KBC_C_P1_LO     8'hC1
`define KBC_C_P1_HI     8'hC2
`define KBC_C_RD_P2     8'hD0
`define KBC_C_WR_P2     8'hD1
`define KBC_C_ECHO_KB   8'hD2
`define KBC_C_ECHO_AUX  8'hD3
`define KBC_C_WR_AUX    8'hD4
`define KBC_C_RD_TEST   8'hE0
`define KBC_C_PULSE_HI  4'hF

// Interface test answers
`define KBC_T_OK        8'h00
`define KBC_T_CLK_LOW   8'h01
`define KBC_T_CLK_HIGH  8'h02
`define KBC_T_DAT_LOW   8'h03
`define KBC_T_DAT_HIGH  8'h04

// Control register fields
`define KBC_CTRL_RESET  8'h00
`define KBC_CTRL_CLK_HI 7
`define KBC_CTRL_CLK_LO 6
`define KBC_CTRL_FAST_PORT_ENABLE  2
`define KBC_CTRL_HGA    1
`define KBC_CTRL_HKB    0

// Fast control register fields
`define KBC_P92_RESET   8'h24
`define KBC_P92_FIXED   8'h24
`define KBC_P92_GATE    1
`define KBC_P92_PULSE   0

// Status register fields
`define KBC_ST_OBF      0
`define KBC_ST_CD       3
`define KBC_ST_INH      4
`define KBC_ST_AUX      5

// Output port two reset: gate low, reset released
`define KBC_P2_RESET    8'h01
`define KBC_P2_GATE     1
`define KBC_P2_RST      0

// Timing
`define KBC_CLK_NS      100
`define KBC_RST_DLY_NS  14000
`define KBC_RST_LOW_NS  6000

`endif

// File: hdl/kbc_pkg.sv
package kbc_pkg;

  typedef enum logic [2:0] {
    PEND_NONE,
    PEND_P2,
    PEND_ECHO_KB,
    PEND_ECHO_AUX,
    PEND_AUX
  } pend_e;

  typedef enum logic [1:0] {
    PL_IDLE,
    PL_DELAY,
    PL_LOW
  } pulse_e;

  typedef enum logic [1:0] {
    NIB_OFF,
    NIB_LO,
    NIB_HI
  } nib_e;

endpackage

// File: hdl/kbc_gate_reset_control.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "kbc_params.svh"

module kbc_gate_reset_control #(
  parameter int CLK_NS = `KBC_CLK_NS
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic [7:0] input_port_one,
  input  wire logic [1:0] test_in,
  input  wire logic       kb_clk_in,
  input  wire logic       kb_data_in,
  input  wire logic       fw_addr_gate,
  input  wire logic       fw_reset_n,
  output logic            addr_line_gate,
  output logic            keyboard_reset_out_n,
  output logic      [1:0] clock_select,
  output logic            kb_if_enable,
  output logic      [7:0] kb_tx_data,
  output logic            kb_tx_valid,
  output logic      [7:0] aux_tx_data,
  output logic            aux_tx_valid
);

  localparam int DLY_CYC = (`KBC_RST_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOW_CYC = (`KBC_RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CW      = 12;

  if (CLK_NS < 1 || DLY_CYC >= (1 << CW) || LOW_CYC < 1) begin : g_bad_clk
    $error("CLK_NS gives reset timing out of counter range");
  end

  // Pin sampling: three stages, accept on agreement of last two
  logic [11:0] pin_s1_q;
  logic [11:0] pin_s2_q;
  logic [11:0] pin_s3_q;
  logic [11:0] pin_q;
  wire  [11:0] pin_raw = {input_port_one, test_in, kb_clk_in, kb_data_in};
  wire  [11:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);

  always_ff @(posedge mclk) begin
    pin_s1_q <= pin_raw;
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
    if (!resetn) begin
      pin_q <= 12'h000;
    end else begin
      pin_q <= (pin_s3_q & pin_agree) | (pin_q & ~pin_agree);
    end
  end

  wire [7:0] p1      = pin_q[11:4];
  wire [1:0] tst     = pin_q[3:2];
  wire       kb_clk  = pin_q[1];
  wire       kb_dat  = pin_q[0];

  // Address decode
  wire wr_data = wr && (addr == `KBC_A_DATA);
  wire wr_cmd  = wr && (addr == `KBC_A_CMD);
  wire wr_p92  = wr && (addr == `KBC_A_P92);
  wire wr_ctrl = wr && (addr == `KBC_A_CTRL);
  wire rd_data = rd && (addr == `KBC_A_DATA);

  // State
  kbc_pkg::pend_e  pend_q;
  kbc_pkg::pulse_e pl_q;
  kbc_pkg::nib_e   nib_q;
  logic [7:0]      ctrl_q;
  logic [1:0]      p92_q;
  logic [7:0]      p2_q;
  logic [7:0]      obuf_q;
  logic            obf_q;
  logic            aux_obf_q;
  logic            cd_q;
  logic            kb_en_q;
  logic [CW-1:0]   cnt_q;

  wire fast_port_enable = ctrl_q[`KBC_CTRL_FAST_PORT_ENABLE];
  wire hga   = ctrl_q[`KBC_CTRL_HGA];
  wire hkb   = ctrl_q[`KBC_CTRL_HKB];

  // Interface test: a low line reads as stuck low
  wire [7:0] kb_test = !kb_clk ? `KBC_T_CLK_LOW :
                       !kb_dat ? `KBC_T_DAT_LOW : `KBC_T_OK;

  // Pulse trigger from even Fx command or fast register bit rising
  wire cmd_pulse = wr_cmd && (wdata[7:4] == `KBC_C_PULSE_HI)
                   && !wdata[0];
  wire p92_pulse = wr_p92 && fast_port_enable && wdata[`KBC_P92_PULSE]
                   && !p92_q[`KBC_P92_PULSE];
  wire pulse_go  = cmd_pulse || p92_pulse;

  // Command byte: result byte and whether it loads the buffer
  logic       res_load;
  logic [7:0] res_byte;

  always_comb begin
    res_load = 1'b1;
    res_byte = 8'h00;
    case (wdata)
      `KBC_C_KB_TEST: res_byte = kb_test;
      `KBC_C_RD_P1:   res_byte = p1;
      `KBC_C_RD_P2:   res_byte = p2_q;
      `KBC_C_RD_TEST: res_byte = {6'h00, tst};
      default:        res_load = 1'b0;
    endcase
  end

  // Host write side and command interpreter
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pend_q    <= kbc_pkg::PEND_NONE;
      nib_q     <= kbc_pkg::NIB_OFF;
      p2_q      <= `KBC_P2_RESET;
      obuf_q    <= 8'h00;
      obf_q     <= 1'b0;
      aux_obf_q <= 1'b0;
      cd_q      <= 1'b0;
      kb_en_q   <= 1'b1;
    end else if (wr_cmd) begin
      cd_q   <= 1'b1;
      pend_q <= kbc_pkg::PEND_NONE;
      nib_q  <= kbc_pkg::NIB_OFF;
      if (res_load) begin
        obuf_q    <= res_byte;
        obf_q     <= 1'b1;
        aux_obf_q <= 1'b0;
      end
      case (wdata)
        `KBC_C_KB_DIS:   kb_en_q <= 1'b0;
        `KBC_C_KB_EN:    kb_en_q <= 1'b1;
        `KBC_C_P1_LO:    nib_q <= kbc_pkg::NIB_LO;
        `KBC_C_P1_HI:    nib_q <= kbc_pkg::NIB_HI;
        `KBC_C_WR_P2:    pend_q <= kbc_pkg::PEND_P2;
        `KBC_C_ECHO_KB:  pend_q <= kbc_pkg::PEND_ECHO_KB;
        `KBC_C_ECHO_AUX: pend_q <= kbc_pkg::PEND_ECHO_AUX;
        `KBC_C_WR_AUX:   pend_q <= kbc_pkg::PEND_AUX;
        default:         pend_q <= kbc_pkg::PEND_NONE;
      endcase
    end else if (wr_data) begin
      cd_q   <= 1'b0;
      pend_q <= kbc_pkg::PEND_NONE;
      case (pend_q)
        kbc_pkg::PEND_P2: begin
          p2_q <= wdata;
        end
        kbc_pkg::PEND_ECHO_KB: begin
          obuf_q    <= wdata;
          obf_q     <= 1'b1;
          aux_obf_q <= 1'b0;
        end
        kbc_pkg::PEND_ECHO_AUX: begin
          obuf_q    <= wdata;
          obf_q     <= 1'b1;
          aux_obf_q <= 1'b1;
        end
        default: begin
        end
      endcase
    end else if (rd_data) begin
      obf_q     <= 1'b0;
      aux_obf_q <= 1'b0;
    end
  end

  // Outgoing bytes to the keyboard or auxiliary device
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      kb_tx_data   <= 8'h00;
      kb_tx_valid  <= 1'b0;
      aux_tx_data  <= 8'h00;
      aux_tx_valid <= 1'b0;
    end else begin
      kb_tx_valid  <= wr_data && (pend_q == kbc_pkg::PEND_NONE) && kb_en_q;
      aux_tx_valid <= wr_data && (pend_q == kbc_pkg::PEND_AUX);
      if (wr_data) begin
        kb_tx_data  <= wdata;
        aux_tx_data <= wdata;
      end
    end
  end

  // Control and fast registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_q <= `KBC_CTRL_RESET;
      p92_q  <= 2'(`KBC_P92_RESET & 8'h03);
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata & 8'hC7;
      end
      if (wr_p92) begin
        p92_q <= wdata[1:0];
      end
    end
  end

  // Reset pulse: delay phase, then low phase; busy ignores triggers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pl_q  <= kbc_pkg::PL_IDLE;
      cnt_q <= '0;
    end else begin
      case (pl_q)
        kbc_pkg::PL_IDLE: begin
          if (pulse_go) begin
            pl_q  <= kbc_pkg::PL_DELAY;
            cnt_q <= CW'(DLY_CYC - 1);
          end
        end
        kbc_pkg::PL_DELAY: begin
          if (cnt_q == '0) begin
            pl_q  <= kbc_pkg::PL_LOW;
            cnt_q <= CW'(LOW_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        kbc_pkg::PL_LOW: begin
          if (cnt_q == '0) begin
            pl_q <= kbc_pkg::PL_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: pl_q <= kbc_pkg::PL_IDLE;
      endcase
    end
  end

  // Output merge; registered so the pins never glitch on select changes
  wire gate_hw  = hga ? p2_q[`KBC_P2_GATE] : fw_addr_gate;
  wire gate_d   = gate_hw | (fast_port_enable & p92_q[`KBC_P92_GATE]);
  wire rst_lvl  = hkb ? p2_q[`KBC_P2_RST] : fw_reset_n;
  wire rst_d    = rst_lvl && (pl_q != kbc_pkg::PL_LOW);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      addr_line_gate       <= 1'b0;
      keyboard_reset_out_n <= 1'b1;
    end else begin
      addr_line_gate       <= gate_d;
      keyboard_reset_out_n <= rst_d;
    end
  end

  assign clock_select = ctrl_q[`KBC_CTRL_CLK_HI:`KBC_CTRL_CLK_LO];
  assign kb_if_enable = kb_en_q;

  // Status byte, upper nibble replaced while a nibble copy runs
  logic [7:0] status;

  always_comb begin
    status = 8'h00;
    status[`KBC_ST_OBF] = obf_q;
    status[`KBC_ST_CD]  = cd_q;
    status[`KBC_ST_INH] = kb_en_q;
    status[`KBC_ST_AUX] = aux_obf_q;
    case (nib_q)
      kbc_pkg::NIB_LO: status[7:4] = p1[3:0];
      kbc_pkg::NIB_HI: status[7:4] = p1[7:4];
      default: begin
      end
    endcase
  end

  // Read mux; unmapped addresses read zero
  logic [7:0] rd_mux;

  always_comb begin
    case (addr)
      `KBC_A_DATA: rd_mux = obuf_q;
      `KBC_A_CMD:  rd_mux = status;
      `KBC_A_P92:  rd_mux = `KBC_P92_FIXED | {6'h00, p92_q};
      `KBC_A_CTRL: rd_mux = ctrl_q;
      default:     rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
    end
  end

endmodule

// File: tb/kbc_gate_reset_control_chk.sv
`timescale 1ns/1ps
`include "kbc_params.svh"
module kbc_gate_reset_control_chk #(
  parameter int CLK_NS = `KBC_CLK_NS
) (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] input_port_one,
  input wire logic [1:0] test_in,
  input wire logic       kb_clk_in,
  input wire logic       kb_data_in,
  input wire logic       fw_addr_gate,
  input wire logic       fw_reset_n,
  input wire logic       addr_line_gate,
  input wire logic       keyboard_reset_out_n,
  input wire logic [1:0] clock_select,
  input wire logic       kb_if_enable,
  input wire logic [7:0] kb_tx_data,
  input wire logic       kb_tx_valid,
  input wire logic [7:0] aux_tx_data,
  input wire logic       aux_tx_valid
);
  // Output flop adds one cycle before the fall is seen
  localparam int DLY = (`KBC_RST_DLY_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int LEN = DLY + (`KBC_RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire cmd_wr = wr && addr == `KBC_A_CMD;
  wire dat_wr = wr && addr == `KBC_A_DATA;
  // Antecedent assumes firmware keeps reset released meanwhile
  sequence fe_go;
    cmd_wr && wdata == 8'hFE && keyboard_reset_out_n && fw_reset_n;
  endsequence
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  AST_KB_TX: assert property (kb_tx_valid |-> $past(dat_wr) && kb_tx_data == $past(wdata))
    else $error("keyboard byte wrong");
  AST_KB_GATED: assert property (dat_wr && !kb_if_enable |=> !kb_tx_valid)
    else $error("keyboard byte while disabled");
  AST_AUX_TX: assert property (aux_tx_valid |-> $past(dat_wr) && aux_tx_data == $past(wdata))
    else $error("aux byte wrong");
  AST_CLK_SEL: assert property (wr && addr == `KBC_A_CTRL |=> clock_select == $past(wdata[7:6]))
    else $error("clock select wrong");
  AST_KB_DIS: assert property (cmd_wr && wdata == `KBC_C_KB_DIS |=> !kb_if_enable)
    else $error("disable ignored");
  AST_KB_EN: assert property (cmd_wr && wdata == `KBC_C_KB_EN |=> kb_if_enable)
    else $error("enable ignored");
  AST_FE_FALL: assert property (fe_go |-> ##DLY keyboard_reset_out_n ##1 !keyboard_reset_out_n)
    else $error("reset fall time wrong");
  AST_FE_LEN: assert property (fe_go |-> ##LEN !keyboard_reset_out_n ##1 keyboard_reset_out_n)
    else $error("reset pulse length wrong");
  cover property (kb_tx_valid);
  cover property (aux_tx_valid);
  cover property ($fell(keyboard_reset_out_n));
endmodule
bind kbc_gate_reset_control kbc_gate_reset_control_chk #(.CLK_NS(CLK_NS)) chk_inst (.*);

// File: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic       mclk,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Data inverted on release so stale bytes never look valid
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    // Read data stand only in this cycle; take them mid-cycle
    @(negedge mclk);
    d = rdata;
  endtask
endmodule

// File: tb/tb_kbc_gate_reset_control.sv
`timescale 1ns/1ps
`include "kbc_params.svh"
module tb_kbc_gate_reset_control;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  addr, wdata, rdata, kb_tx_data, aux_tx_data;
  logic        wr, rd, addr_line_gate, keyboard_reset_out_n, kb_if_enable;
  logic        kb_tx_valid, aux_tx_valid;
  logic [1:0]  clock_select;
  logic [7:0]  input_port_one = 8'h00;
  logic [1:0]  test_in = 2'h0;
  logic        kb_clk_in = 1'b1;
  logic        kb_data_in = 1'b1;
  logic        fw_addr_gate = 1'b0;
  logic        fw_reset_n = 1'b1;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n;
  logic [31:0] seed = 34;
  logic [7:0]  v, x, r;
  byte unsigned q[$];
  // Short timing: 14 cycles delay, 6 cycles low
  kbc_gate_reset_control #(.CLK_NS(1000)) kbc_gate_reset_control_inst (.*);
  host_model host_model_inst (.*);
  always #50 mclk = ~mclk;
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task put(input logic [7:0] a, input logic [7:0] d);
    host_model_inst.put(a, d);
  endtask
  task get(input logic [7:0] a);
    host_model_inst.get(a, v);
  endtask
  task obuf();
    get(`KBC_A_DATA);
    chk(v, q.pop_front());
  endtask
  // Window covers delay plus low time with margin
  task count_low();
    n = 0;
    repeat (30) begin
      @(posedge mclk);
      if (!keyboard_reset_out_n) n++;
    end
  endtask
  task print_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    get(`KBC_A_P92);
    chk(v, 8'h24);
    get(`KBC_A_CTRL);
    chk(v, 8'h00);
    get(`KBC_A_CMD);
    chk(v, 8'h10);
    chk({6'h00, addr_line_gate, keyboard_reset_out_n}, 8'h01);
    r = rnd();
    put(`KBC_A_CTRL, r);
    get(`KBC_A_CTRL);
    chk(v, r & 8'hC7);
    chk({6'h00, clock_select}, {6'h00, r[7:6]});
    put(`KBC_A_CTRL, 8'h00);
    r = rnd() & 8'hFE;
    put(`KBC_A_P92, r);
    get(`KBC_A_P92);
    chk(v, 8'h24 | (r & 8'h02));
    chk({7'h00, addr_line_gate}, 8'h00);
    put(`KBC_A_CTRL, 8'h04);
    repeat (2) @(posedge mclk);
    chk({7'h00, addr_line_gate}, {7'h00, r[1]});
    put(`KBC_A_P92, 8'h00);
    input_port_one <= rnd();
    repeat (4) @(posedge mclk);
    put(`KBC_A_CMD, `KBC_C_RD_P1);
    q.push_back(input_port_one);
    get(`KBC_A_CMD);
    chk(v & 8'h09, 8'h09);
    obuf();
    put(`KBC_A_CMD, `KBC_C_P1_LO);
    get(`KBC_A_CMD);
    chk(v >> 4, input_port_one & 8'h0F);
    put(`KBC_A_CMD, `KBC_C_P1_HI);
    get(`KBC_A_CMD);
    chk(v >> 4, input_port_one >> 4);
    put(`KBC_A_CTRL, 8'h03);
    x = rnd();
    put(`KBC_A_CMD, `KBC_C_WR_P2);
    put(`KBC_A_DATA, x);
    repeat (2) @(posedge mclk);
    chk({6'h00, addr_line_gate, keyboard_reset_out_n}, x & 8'h03);
    put(`KBC_A_CMD, `KBC_C_RD_P2);
    q.push_back(x);
    obuf();
    put(`KBC_A_CTRL, 8'h00);
    for (int i = 0; i < 2; i++) begin
      x = rnd();
      put(`KBC_A_CMD, i ? `KBC_C_ECHO_AUX : `KBC_C_ECHO_KB);
      put(`KBC_A_DATA, x);
      q.push_back(x);
      get(`KBC_A_CMD);
      chk(v & 8'h21, i ? 8'h21 : 8'h01);
      obuf();
    end
    x = rnd();
    put(`KBC_A_CMD, `KBC_C_WR_AUX);
    put(`KBC_A_DATA, x);
    @(negedge mclk);
    chk(aux_tx_data, x);
    chk({7'h00, aux_tx_valid}, 8'h01);
    test_in <= rnd() & 8'h03;
    repeat (4) @(posedge mclk);
    put(`KBC_A_CMD, `KBC_C_RD_TEST);
    q.push_back({6'h00, test_in});
    obuf();
    for (int i = 0; i < 3; i++) begin
      kb_clk_in <= i > 0;
      kb_data_in <= i > 1;
      repeat (4) @(posedge mclk);
      put(`KBC_A_CMD, `KBC_C_KB_TEST);
      q.push_back(i == 0 ? 8'h01 : i == 1 ? 8'h03 : 8'h00);
      obuf();
    end
    put(`KBC_A_CMD, `KBC_C_KB_DIS);
    put(`KBC_A_DATA, rnd());
    chk({7'h00, kb_if_enable}, 8'h00);
    put(`KBC_A_CMD, `KBC_C_KB_EN);
    x = rnd();
    put(`KBC_A_DATA, x);
    @(negedge mclk);
    chk(kb_tx_data, x);
    chk({7'h00, kb_tx_valid}, 8'h01);
    for (int i = 0; i < 2; i++) begin
      put(`KBC_A_CMD, i ? 8'hF1 : 8'hFE);
      count_low();
      chk(n[7:0], i ? 8'h00 : 8'h06);
    end
    put(`KBC_A_CTRL, 8'h04);
    repeat (2) begin
      put(`KBC_A_P92, 8'h01);
      count_low();
      chk(n[7:0], 8'h06);
      put(`KBC_A_P92, 8'h00);
    end
    print_verdict();
  end
endmodule
